/* src/srw_pkg.sv */
package srw_pkg;

    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CFG      = 8'h04;
    localparam logic [7:0] ADDR_FS1      = 8'h08;
    localparam logic [7:0] ADDR_FS2      = 8'h0C;
    localparam logic [7:0] ADDR_INT_REF  = 8'h10;
    localparam logic [7:0] ADDR_DECEL    = 8'h14;
    localparam logic [7:0] ADDR_WIN_HI   = 8'h18;
    localparam logic [7:0] ADDR_WIN_LO   = 8'h1C;
    localparam logic [7:0] ADDR_AUX_VAL  = 8'h20;
    localparam logic [7:0] ADDR_STATUS   = 8'h24;
    localparam logic [7:0] ADDR_SPD_REF  = 8'h28;

    // ------------------------------------------------------------
    // drive control word fields
    // ------------------------------------------------------------
    localparam int CW_FULL_SCALE  = 0;
    localparam int CW_VIB_SUPP    = 1;
    localparam int CW_RESERVED    = 2;
    localparam int CW_HOLD        = 3;
    localparam int CW_LEFT_LIM    = 4;
    localparam int CW_RIGHT_LIM   = 5;
    localparam int CW_STOP        = 6;
    localparam int CW_WIN_ABS     = 7;
    localparam int CW_TRQ_LIM     = 8;
    localparam int CW_SW_EN       = 9;
    localparam int CW_AUX_SEL     = 11;
    localparam int CW_DIGITAL     = 12;
    localparam int CW_INT_FREQ    = 13;
    localparam logic [15:0] CW_RESET     = 16'h0200;
    localparam logic [15:0] CW_WR_MASK   = 16'h3BFF;

    // config register: aux torque/speed select
    localparam int CFG_AUX_TRQ    = 0;
    localparam logic [15:0] CFG_RESET    = 16'h0000;

    // status register fields
    localparam int ST_IN_SPEED    = 0;
    localparam int ST_CONV_EN     = 1;
    localparam int ST_RAMPING     = 2;

    // ------------------------------------------------------------
    // reset values and scaling
    // ------------------------------------------------------------
    localparam logic [15:0] FS1_RESET    = 16'h0000;
    localparam logic [15:0] FS2_RESET    = 16'h0000;
    localparam logic [15:0] ZERO16       = 16'h0000;
    localparam logic [15:0] TRQ_FULL     = 16'h7FFF;
    localparam int          SCALE_SHIFT  = 14;
    localparam int          AUX_LSB      = 8;

    // ------------------------------------------------------------
    // timing: ramp step period
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 50;
    localparam int RAMP_TICK_US = 1000;
    localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * CLK_MHZ;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRW_TRACK = 2'b00,
        SRW_RAMP  = 2'b01
    } srw_mode_t;

    typedef struct packed {
        logic signed [15:0] analogue_main;
        logic signed [15:0] reserved_ref;
        logic signed [15:0] frequency_reference;
        logic signed [15:0] motor_speed;
        logic signed [15:0] motor_torque;
        logic signed [15:0] aux_analogue_reading;
    } srw_meas_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } srw_bus_t;

endpackage

/* src/srw_scale.sv */
`timescale 1ns/100ps
module srw_scale
    import srw_pkg::*;
(
    // operands
    input  wire logic signed [15:0] sample,
    input  wire logic        [15:0] gain,
    // result
    output logic signed [15:0]      scaled
);
    import srw_pkg::*;

    logic signed [32:0] prod;
    logic signed [32:0] shifted;

    // full-scale gain over 2^14 input counts, saturated to 16 bits
    always_comb begin
        prod    = 33'(sample) * $signed({17'h00000, gain});
        shifted = prod >>> SCALE_SHIFT;
        if (shifted > 33'sh0_0000_7FFF) begin
            scaled = 16'sh7FFF;
        end else if (shifted < -33'sh0_0000_8000) begin
            scaled = -16'sh8000;
        end else begin
            scaled = shifted[15:0];
        end
    end
endmodule

/* src/srw_ctrl.sv */
`timescale 1ns/100ps
module srw_ctrl
    import srw_pkg::*;
#(
    parameter int RAMP_TICKS = RAMP_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               sys_rst,
    // register port
    input  wire srw_pkg::srw_bus_t  bus,
    output logic [15:0]             rdata,
    // measured and external references
    input  wire srw_pkg::srw_meas_t meas,
    input  wire logic               hw_enable,
    input  wire logic               drive_ok,
    // drive outputs
    output logic signed [15:0]      speed_ref,
    output logic                    vib_suppress_en,
    output logic                    torque_limit_en,
    output logic [15:0]             torque_limit,
    output logic                    converter_enable,
    output logic [7:0]              aux_out,
    output logic                    in_speed_flag
);
    import srw_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]        drive_control_word;
        logic [15:0]        cfg;
        logic [15:0]        first_full_scale;
        logic [15:0]        second_full_scale;
        logic signed [15:0] internal_reference;
        logic [15:0]        decel_ramp;
        logic signed [15:0] speed_window_upper;
        logic signed [15:0] speed_window_lower;
        logic signed [15:0] aux_output_value;
        logic signed [15:0] held;
        logic signed [15:0] ref_out;
        srw_mode_t          mode;
        logic [31:0]        tick_cnt;
        logic [15:0]        rdata;
        logic               vib;
        logic               trq_en;
        logic [15:0]        trq;
        logic               conv_en;
        logic [7:0]         aux;
        logic               in_speed;
    } srw_state_t;

    srw_state_t s;
    srw_state_t next_s;

    logic signed [15:0] analogue_scaled;
    logic [15:0]        full_scale;

    assign full_scale = s.drive_control_word[CW_FULL_SCALE] ?
                        s.second_full_scale : s.first_full_scale;

    srw_scale u_scale (
        .sample (meas.analogue_main),
        .gain   (full_scale),
        .scaled (analogue_scaled)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic signed [15:0] selected;
    logic signed [16:0] ref17;
    logic signed [16:0] step17;
    logic signed [16:0] diff17;
    logic signed [16:0] hi17;
    logic signed [16:0] lo17;
    logic               demand_neg;
    logic               ramp_req;
    logic               tick;
    logic [15:0]        cw;

    always_comb begin
        next_s     = s;
        cw         = s.drive_control_word;
        selected   = ZERO16;
        ref17      = {s.ref_out[15], s.ref_out};
        step17     = {1'b0, s.decel_ramp};
        diff17     = 17'sh00000;
        hi17       = {s.speed_window_upper[15], s.speed_window_upper};
        lo17       = {s.speed_window_lower[15], s.speed_window_lower};
        demand_neg = 1'b0;
        ramp_req   = 1'b0;
        tick       = (s.tick_cnt == 32'(RAMP_TICKS - 1));

        // register writes; unmapped and read-only addresses ignore writes
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CTRL:    next_s.drive_control_word = bus.wdata & CW_WR_MASK;
                ADDR_CFG:     next_s.cfg                = bus.wdata;
                ADDR_FS1:     next_s.first_full_scale   = bus.wdata;
                ADDR_FS2:     next_s.second_full_scale  = bus.wdata;
                ADDR_INT_REF: next_s.internal_reference = bus.wdata;
                ADDR_DECEL:   next_s.decel_ramp         = bus.wdata;
                ADDR_WIN_HI:  next_s.speed_window_upper = bus.wdata;
                ADDR_WIN_LO:  next_s.speed_window_lower = bus.wdata;
                ADDR_AUX_VAL: next_s.aux_output_value   = bus.wdata;
                default:      next_s.cfg                = s.cfg;
            endcase
        end

        // register reads, answered in the next cycle only
        next_s.rdata = ZERO16;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL:    next_s.rdata = s.drive_control_word;
                ADDR_CFG:     next_s.rdata = s.cfg;
                ADDR_FS1:     next_s.rdata = s.first_full_scale;
                ADDR_FS2:     next_s.rdata = s.second_full_scale;
                ADDR_INT_REF: next_s.rdata = s.internal_reference;
                ADDR_DECEL:   next_s.rdata = s.decel_ramp;
                ADDR_WIN_HI:  next_s.rdata = s.speed_window_upper;
                ADDR_WIN_LO:  next_s.rdata = s.speed_window_lower;
                ADDR_AUX_VAL: next_s.rdata = s.aux_output_value;
                ADDR_STATUS: begin
                    next_s.rdata[ST_IN_SPEED] = s.in_speed;
                    next_s.rdata[ST_CONV_EN]  = s.conv_en;
                    next_s.rdata[ST_RAMPING]  = (s.mode == SRW_RAMP);
                end
                ADDR_SPD_REF: next_s.rdata = s.ref_out;
                default:      next_s.rdata = ZERO16;
            endcase
        end

        // ramp step timer, free running
        next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;

        if (cw[CW_RESERVED]) begin
            selected = meas.reserved_ref;
        end else if (cw[CW_DIGITAL]) begin
            if (cw[CW_INT_FREQ]) begin
                selected = meas.frequency_reference;
            end else begin
                selected = s.internal_reference;
            end
        end else begin
            selected = analogue_scaled;
        end

        next_s.held = cw[CW_HOLD] ? s.held : selected;

        // both limit switches guard negative demand as specified
        demand_neg = s.held[15];
        ramp_req = cw[CW_STOP]
                 | (cw[CW_LEFT_LIM] & demand_neg)
                 | (cw[CW_RIGHT_LIM] & demand_neg);

        case (s.mode)
            SRW_TRACK: begin
                next_s.ref_out = s.held;
                if (ramp_req) begin
                    next_s.ref_out = s.ref_out;
                    next_s.mode    = SRW_RAMP;
                end
            end
            SRW_RAMP: begin
                if (!ramp_req) begin
                    next_s.mode    = SRW_TRACK;
                end else if (tick) begin
                    // step toward zero, never overshooting past it
                    if (ref17 > step17) begin
                        next_s.ref_out = 16'(ref17 - step17);
                    end else if (ref17 < -step17) begin
                        next_s.ref_out = 16'(ref17 + step17);
                    end else begin
                        next_s.ref_out = ZERO16;
                    end
                end
            end
            default: begin
                next_s.mode = SRW_TRACK;
            end
        endcase

        if (cw[CW_WIN_ABS]) begin
            diff17 = {meas.motor_speed[15], meas.motor_speed};
        end else begin
            diff17 = ref17 - {meas.motor_speed[15], meas.motor_speed};
        end
        next_s.in_speed = (diff17 < hi17) && (diff17 > lo17);

        next_s.vib = cw[CW_VIB_SUPP];

        next_s.trq_en = cw[CW_TRQ_LIM];
        next_s.trq    = cw[CW_TRQ_LIM] ? meas.aux_analogue_reading : TRQ_FULL;

        next_s.conv_en = cw[CW_SW_EN] & hw_enable & drive_ok;

        // aux output source; 8-bit output keeps the top byte
        if (cw[CW_AUX_SEL]) begin
            next_s.aux = s.aux_output_value[AUX_LSB +: 8];
        end else if (s.cfg[CFG_AUX_TRQ]) begin
            next_s.aux = meas.motor_torque[AUX_LSB +: 8];
        end else begin
            next_s.aux = meas.motor_speed[AUX_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s                    <= '0;
            s.drive_control_word <= CW_RESET;
            s.cfg                <= CFG_RESET;
            s.first_full_scale   <= FS1_RESET;
            s.second_full_scale  <= FS2_RESET;
            s.trq                <= TRQ_FULL;
            s.mode               <= SRW_TRACK;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign rdata            = s.rdata;
    assign speed_ref        = s.ref_out;
    assign vib_suppress_en  = s.vib;
    assign torque_limit_en  = s.trq_en;
    assign torque_limit     = s.trq;
    assign converter_enable = s.conv_en;
    assign aux_out          = s.aux;
    assign in_speed_flag    = s.in_speed;

endmodule

/* bench/srw_ctrl_checker.sv */
`timescale 1ns/100ps
module srw_ctrl_checker
    import srw_pkg::*;
(
    // clock and reset
    input wire logic               clock,
    input wire logic               sys_rst,
    // watched ports
    input wire srw_pkg::srw_bus_t  bus,
    input wire logic [15:0]        rdata,
    input wire srw_pkg::srw_meas_t meas,
    input wire logic               hw_enable,
    input wire logic               drive_ok,
    input wire logic signed [15:0] speed_ref,
    input wire logic               vib_suppress_en,
    input wire logic               torque_limit_en,
    input wire logic [15:0]        torque_limit,
    input wire logic               converter_enable
);
    // ----------------------------------------
    // steps of a control word update
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence ctrl_wr;
        bus.wr && bus.addr == ADDR_CTRL;
    endsequence
    // three quiet cycles let the word and its derived outputs land
    sequence settled;
        ctrl_wr ##1 !bus.wr [*3];
    endsequence
    sequence stop_settled;
        (ctrl_wr and bus.wdata[CW_STOP]) ##1 !bus.wr [*3];
    endsequence
    a_conv_needs_en: assert property (
        converter_enable |-> $past(hw_enable) && $past(drive_ok))
        else $error("converter enabled without hardware enable");
    a_conv_sw_off: assert property (
        settled |-> !converter_enable || $past(bus.wdata[CW_SW_EN], 3))
        else $error("converter enabled with software enable low");
    a_vib_follow: assert property (
        settled |-> vib_suppress_en == $past(bus.wdata[CW_VIB_SUPP], 3))
        else $error("vibration suppress does not follow control word");
    a_trq_en_follow: assert property (
        settled |-> torque_limit_en == $past(bus.wdata[CW_TRQ_LIM], 3))
        else $error("torque limit enable does not follow control word");
    a_trq_off_full: assert property (!torque_limit_en |-> torque_limit == TRQ_FULL)
        else $error("torque limit not full scale while disabled");
    a_trq_on_aux: assert property (
        torque_limit_en |-> torque_limit == $past(meas.aux_analogue_reading))
        else $error("torque limit not taken from auxiliary reading");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == ZERO16)
        else $error("read data present without a read");
    a_stop_no_rise: assert property (
        stop_settled |-> (speed_ref >= 0 ? speed_ref <= $past(speed_ref)
                                         : speed_ref >= $past(speed_ref)))
        else $error("speed reference grows while stopping");
endmodule
bind srw_ctrl srw_ctrl_checker i_chk (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .meas(meas), .hw_enable(hw_enable), .drive_ok(drive_ok), .speed_ref(speed_ref),
    .vib_suppress_en(vib_suppress_en), .torque_limit_en(torque_limit_en),
    .torque_limit(torque_limit), .converter_enable(converter_enable));

/* bench/tb_srw_ctrl.sv */
`timescale 1ns/100ps
module tb_srw_ctrl;
    import srw_pkg::*;
    logic               clock = 1'b0;
    logic               sys_rst = 1'b1;
    srw_bus_t           bus = '0;
    srw_meas_t          meas = '0;
    logic               hw_enable = 1'b1;
    logic               drive_ok = 1'b1;
    logic [15:0]        rdata;
    logic signed [15:0] speed_ref;
    logic               vib;
    logic               trq_en;
    logic [15:0]        trq;
    logic               conv;
    logic [7:0]         aux_out;
    logic               in_speed;
    logic [15:0]        d;
    int                 err_count = 0;
    int                 checks_done = 0;
    int                 cycles = 0;

    // short ramp tick keeps ramps to a few dozen cycles
    srw_ctrl #(.RAMP_TICKS(4)) i_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
        .meas(meas), .hw_enable(hw_enable), .drive_ok(drive_ok), .speed_ref(speed_ref),
        .vib_suppress_en(vib), .torque_limit_en(trq_en), .torque_limit(trq),
        .converter_enable(conv), .aux_out(aux_out), .in_speed_flag(in_speed));

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        // read data stand for this one cycle only
        @(posedge clock);
        v = rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL, d);
        check(d, 16'h0200);
        check(conv, 16'h0001);
        check(trq, 16'h7FFF);
        rd(ADDR_CFG, d);
        check(d, 16'h0000);
        rd(8'h3C, d);
        check(d, 16'h0000);
        wr(ADDR_CTRL, 16'hFFFF);
        rd(ADDR_CTRL, d);
        check(d, 16'h3BFF);
        wr(ADDR_CTRL, 16'h0200);
    endtask
    task automatic t_source();
        logic [15:0] cw [6] = '{16'h0200, 16'h0201, 16'h1200, 16'h1201, 16'h3200, 16'h0204};
        logic [15:0] ex [6] = '{16'h03E8, 16'h01F4, 16'h012C, 16'h012C, 16'h02BC, 16'h0384};
        meas.analogue_main <= 16'h03E8;
        meas.frequency_reference <= 16'h02BC;
        meas.reserved_ref <= 16'h0384;
        wr(ADDR_FS1, 16'h4000);
        wr(ADDR_FS2, 16'h2000);
        wr(ADDR_INT_REF, 16'h012C);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CTRL, cw[i]);
            wait_cyc(6);
            check(speed_ref, ex[i]);
        end
    endtask
    task automatic t_hold_ramp();
        wr(ADDR_DECEL, 16'h0064);
        wr(ADDR_CTRL, 16'h0208);
        meas.analogue_main <= 16'h07D0;
        wait_cyc(6);
        // hold keeps the reserved value taken before the hold, not the new input
        check(speed_ref, 16'h0384);
        wr(ADDR_CTRL, 16'h0248);
        wait_cyc(60);
        check(speed_ref, 16'h0000);
        for (int b = CW_LEFT_LIM; b <= CW_RIGHT_LIM; b++) begin
            meas.analogue_main <= 16'h03E8;
            wr(ADDR_CTRL, 16'h0200 | (16'h0001 << b));
            wait_cyc(60);
            check(speed_ref, 16'h03E8);
            meas.analogue_main <= 16'hFC18;
            wait_cyc(60);
            check(speed_ref, 16'h0000);
        end
        meas.analogue_main <= 16'h03E8;
        wr(ADDR_CTRL, 16'h0200);
        wait_cyc(6);
    endtask
    task automatic t_outputs();
        logic [15:0] wc [4] = '{16'h0280, 16'h0280, 16'h0200, 16'h0200};
        logic [15:0] ms [4] = '{16'h0032, 16'h03E8, 16'h03E8, 16'h0032};
        wr(ADDR_CTRL, 16'h0302);
        meas.aux_analogue_reading <= 16'h1111;
        wait_cyc(4);
        check(vib, 16'h0001);
        check(trq_en, 16'h0001);
        check(trq, 16'h1111);
        wr(ADDR_CTRL, 16'h0000);
        wait_cyc(4);
        check(conv, 16'h0000);
        wr(ADDR_CTRL, 16'h0200);
        drive_ok <= 1'b0;
        wait_cyc(4);
        check(conv, 16'h0000);
        drive_ok <= 1'b1;
        meas.motor_speed <= 16'h1234;
        meas.motor_torque <= 16'h5600;
        // aux output follows a register write two edges after the write strobe
        wr(ADDR_AUX_VAL, 16'h7800);
        wait_cyc(2);
        check(aux_out, 16'h0012);
        wr(ADDR_CFG, 16'h0001);
        wait_cyc(2);
        check(aux_out, 16'h0056);
        wr(ADDR_CTRL, 16'h0A00);
        wait_cyc(2);
        check(aux_out, 16'h0078);
        wr(ADDR_WIN_HI, 16'h0064);
        wr(ADDR_WIN_LO, 16'hFF9C);
        for (int i = 0; i < 4; i++) begin
            meas.motor_speed <= ms[i];
            wr(ADDR_CTRL, wc[i]);
            wait_cyc(4);
            check(in_speed, {15'h0, i == 0 || i == 2});
        end
    endtask

    initial begin
        wait_cyc(16);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_source();
        t_hold_ramp();
        t_outputs();
        close_out();
    end
endmodule
